// ---- rtl/rtcct_core.sv ----
// rtc control, divider chain, frequency trim and clock interrupt
`timescale 1ns/100ps

// Functional notes
// (RULE1) both select bits set: 1.5 s interval
// (RULE2) select 1 ext 0: 1 s; select 0: minute
// (RULE3) software writes zero to both test bits
// (RULE4) clock-output enable puts 16 kHz on pin
// (RULE5) port flip-flop and pin stay readable, writable
// (RULE6) run 0 stops oscillator, resets divider chain
// (RULE7) flag set by interval end or software one
// (RULE8) interrupt enable bit gates interrupt request
// (RULE9) control register at 20h, documented bit order
// (RULE10) 8-bit trim register at 21h
// (RULE11) software picks trim from measured frequency
// (RULE12) first short period after minute: trim stretch
// (RULE13) both registers reset to 00h
// (RULE14) interval falling edge sets flag; or external
// (RULE15) flag sets regardless; request is flag and enable
module rtcct_core #(
  parameter int OSC_DIV = rtcct_pkg::OSC_DIV
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic port_ff_wr,
  input wire logic port_ff_wdata,
  output logic port_ff_q,
  input wire logic shared_port_clock_pin_in,
  output logic shared_port_clock_pin_out,
  output logic shared_port_clock_pin_oe,
  output logic pin_level,
  input wire logic ext_int_n,
  output logic osc_enable,
  output logic divided_clock_output,
  output logic rtc_int_request,
  output logic cpu_int_request
);
  import rtcct_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers and chain state
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] trim_reg;
  logic [7:0] rdata_reg;
  logic [OSC_CNT_W-1:0] osc_cnt_reg;
  logic clk16_reg;
  logic [8:0] prescale_reg;
  logic [8:0] prescale_next;
  logic [4:0] sec_cnt_reg;
  logic [5:0] half_cnt_reg;
  logic [5:0] min_cnt_reg;
  logic trim_win_reg;
  logic trim_done_reg;
  logic port_ff_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic ext_meta_reg;
  logic ext_sync_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire ctrl_sel = (reg_addr == CTRL_ADDR);
  wire trim_sel = (reg_addr == TRIM_ADDR);
  wire ctrl_wr = reg_wr && ctrl_sel; // RULE9
  wire trim_wr = reg_wr && trim_sel; // RULE10

  // control fields
  wire run = ctrl_reg[RUN_BIT];
  wire its = ctrl_reg[ITS_BIT];
  wire ext_sel = ctrl_reg[EXT_SEL_BIT];
  wire clkout_en = ctrl_reg[CLKOUT_EN_BIT];
  wire clk_irq_flag = ctrl_reg[FLAG_BIT];
  wire clk_irq_en = ctrl_reg[IRQ_EN_BIT];

  // interval choice, one-hot
  rtcct_interval_type interval_sel;
  assign interval_sel = !its ? IVL_MIN : (ext_sel ? IVL_HALF : IVL_SEC); // RULE1 RULE2

  ////////////////////////////////////////////////////////////////////////////
  // divider chain event decode
  wire osc_tick = run && (osc_cnt_reg == OSC_CNT_W'(OSC_DIV - 1));
  wire tick16 = osc_tick && clk16_reg; // falling edge of the 16 kHz clock
  wire trim_hit = trim_win_reg && !trim_done_reg && (trim_reg != TRIM_RESET)
                  && (prescale_reg == {1'b0, trim_reg}); // RULE12
  wire tick32 = tick16 && !trim_hit && (prescale_reg == PRESCALE_LAST);
  wire sec_evt = tick32 && (sec_cnt_reg == SEC_LAST);
  wire half_evt = tick32 && (half_cnt_reg == HALF_LAST);
  wire min_evt = sec_evt && (min_cnt_reg == MIN_LAST);

  // the selected interval ends on the falling edge of its clock
  logic interval_evt;
  always_comb begin
    interval_evt = 1'b0;
    unique case (interval_sel)
      IVL_MIN: interval_evt = min_evt; // RULE2
      IVL_SEC: interval_evt = sec_evt; // RULE2
      IVL_HALF: interval_evt = half_evt; // RULE1
    endcase
  end

  // the trim window closes at the first short period after the minute
  wire win_end = (interval_sel == IVL_HALF) ? half_evt : sec_evt;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator stand-in: a tick every OSC_DIV reference cycles
  assign osc_enable = run; // RULE6
  always_ff @(posedge ref_clk) begin
    if (!rstn || !run || osc_tick) begin
      osc_cnt_reg <= '0; // RULE6
    end else begin
      osc_cnt_reg <= osc_cnt_reg + OSC_CNT_W'(1);
    end
  end

  // 16 kHz divided clock
  always_ff @(posedge ref_clk) begin
    if (!rstn || !run) begin
      clk16_reg <= 1'b0; // RULE6
    end else if (osc_tick) begin
      clk16_reg <= !clk16_reg;
    end
  end
  assign divided_clock_output = clk16_reg;

  // divide-by-512 stage: trim match restarts it, counting those clocks twice
  always_comb begin
    prescale_next = prescale_reg;
    if (tick16) begin
      if (trim_hit) begin
        prescale_next = '0; // RULE12
      end else begin
        prescale_next = prescale_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || !run) begin
      prescale_reg <= '0; // RULE6
    end else begin
      prescale_reg <= prescale_next;
    end
  end

  // second, 1.5 s and minute counters; 40 x 1.5 s fits a minute exactly
  always_ff @(posedge ref_clk) begin
    if (!rstn || !run) begin
      sec_cnt_reg <= '0; // RULE6
      half_cnt_reg <= '0;
      min_cnt_reg <= '0;
    end else if (tick32) begin
      sec_cnt_reg <= sec_cnt_reg + 5'h01;
      half_cnt_reg <= half_evt ? 6'h00 : half_cnt_reg + 6'h01;
      if (sec_evt) begin
        min_cnt_reg <= min_evt ? 6'h00 : min_cnt_reg + 6'h01;
      end
    end
  end

  // trim window: opens at each minute, one restart per window
  always_ff @(posedge ref_clk) begin
    if (!rstn || !run) begin
      trim_win_reg <= 1'b0;
      trim_done_reg <= 1'b0;
    end else if (min_evt) begin
      trim_win_reg <= 1'b1; // RULE12
      trim_done_reg <= 1'b0;
    end else begin
      if (win_end) begin
        trim_win_reg <= 1'b0;
      end
      if (tick16 && trim_hit) begin
        trim_done_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: a hardware set of the flag wins over a software clear
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = reg_wdata; // RULE9
    end
    if (interval_evt) begin
      ctrl_next[FLAG_BIT] = 1'b1; // RULE7 RULE14 RULE15
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET; // RULE13
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // trim register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      trim_reg <= TRIM_RESET; // RULE13
    end else if (trim_wr) begin
      trim_reg <= reg_wdata; // RULE10
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  wire [7:0] rd_mux = ctrl_sel ? ctrl_reg : (trim_sel ? trim_reg : UNMAPPED_DATA);
  always_ff @(posedge ref_clk) begin
    if (!rstn || !reg_rd) begin
      rdata_reg <= UNMAPPED_DATA;
    end else begin
      rdata_reg <= rd_mux; // RULE9 RULE10
    end
  end
  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // shared port pin: port flip-flop stays live while the clock is routed out
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      port_ff_reg <= 1'b1; // quasi-bidirectional lines idle high
    end else if (port_ff_wr) begin
      port_ff_reg <= port_ff_wdata; // RULE5
    end
  end
  assign port_ff_q = port_ff_reg; // RULE5

  // pin and external interrupt come from outside: two flops first
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      ext_meta_reg <= 1'b1;
      ext_sync_n_reg <= 1'b1;
    end else begin
      pin_meta_reg <= shared_port_clock_pin_in;
      pin_sync_reg <= pin_meta_reg;
      ext_meta_reg <= ext_int_n;
      ext_sync_n_reg <= ext_meta_reg;
    end
  end
  assign pin_level = pin_sync_reg; // RULE5

  // quasi-bidirectional drive: low strongly, or the clock when routed
  assign shared_port_clock_pin_out = clkout_en ? clk16_reg : port_ff_reg; // RULE4
  assign shared_port_clock_pin_oe = clkout_en || !port_ff_reg; // RULE4

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request, or-combined with the external line for stop wake-up
  assign rtc_int_request = clk_irq_flag && clk_irq_en; // RULE8 RULE15
  assign cpu_int_request = rtc_int_request || !ext_sync_n_reg; // RULE14

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // helper: 32 Hz ticks since the chain started or the last interval end;
  // trusted only while the interval choice is left alone under a running chain
  logic [5:0] chk_ticks_reg;
  logic chk_valid_reg;
  always_ff @(posedge ref_clk) begin
    if (!rstn || !run) begin
      chk_ticks_reg <= 6'h00;
      chk_valid_reg <= 1'b1;
    end else begin
      if (interval_evt) begin
        chk_ticks_reg <= 6'h00;
      end else if (tick32) begin
        chk_ticks_reg <= chk_ticks_reg + 6'h01;
      end
      if ((ctrl_next[EXT_SEL_BIT] != ext_sel) || (ctrl_next[ITS_BIT] != its)) begin
        chk_valid_reg <= 1'b0;
      end
    end
  end

  sequence s_interval_end;
    interval_evt;
  endsequence

  sequence s_clear_meets_set;
    interval_evt && ctrl_wr && !reg_wdata[FLAG_BIT];
  endsequence

  sequence s_flag_stands;
    clk_irq_flag;
  endsequence

  property p_flag_hw_set;
    @(posedge ref_clk) disable iff (!rstn)
      s_interval_end |=> s_flag_stands;
  endproperty
  a_flag_hw_set: assert property (p_flag_hw_set) else $error("flag not set at interval end"); // RULE7

  property p_flag_sw_only_clear;
    @(posedge ref_clk) disable iff (!rstn)
      clk_irq_flag && !(ctrl_wr && !reg_wdata[FLAG_BIT]) |=> clk_irq_flag;
  endproperty
  a_flag_sw_only_clear: assert property (p_flag_sw_only_clear) else $error("flag lost"); // RULE7

  property p_set_beats_clear;
    @(posedge ref_clk) disable iff (!rstn)
      s_clear_meets_set |=> s_flag_stands;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat set"); // RULE15

  // 1.5 s is 48 ticks of 32 Hz, a second 32 ticks
  property p_half_interval;
    @(posedge ref_clk) disable iff (!rstn)
      its && ext_sel && chk_valid_reg |-> interval_evt == (tick32 && (chk_ticks_reg == HALF_LAST));
  endproperty
  a_half_interval: assert property (p_half_interval) else $error("1.5 s select wrong"); // RULE1

  property p_sec_min_interval;
    @(posedge ref_clk) disable iff (!rstn)
      its ? (ext_sel || !chk_valid_reg
             || (interval_evt == (tick32 && (chk_ticks_reg == {1'b0, SEC_LAST}))))
          : (!interval_evt || (sec_evt && (min_cnt_reg == MIN_LAST)));
  endproperty
  a_sec_min_interval: assert property (p_sec_min_interval) else $error("interval wrong"); // RULE2

  property p_run_stop;
    @(posedge ref_clk) disable iff (!rstn)
      !run |=> (prescale_reg == 9'h000) && (osc_cnt_reg == '0) && !clk16_reg && !interval_evt;
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("chain runs while stopped"); // RULE6

  property p_clock_out;
    @(posedge ref_clk) disable iff (!rstn)
      clkout_en |-> shared_port_clock_pin_oe && (shared_port_clock_pin_out == clk16_reg);
  endproperty
  a_clock_out: assert property (p_clock_out) else $error("clock not on pin"); // RULE4

  property p_port_ff_write;
    @(posedge ref_clk) disable iff (!rstn)
      port_ff_wr |=> port_ff_q == $past(port_ff_wdata);
  endproperty
  a_port_ff_write: assert property (p_port_ff_write) else $error("port flip-flop write lost"); // RULE5

  property p_irq_gate;
    @(posedge ref_clk) disable iff (!rstn)
      ctrl_wr |=> rtc_int_request == ($past(reg_wdata[IRQ_EN_BIT])
                                      && ($past(reg_wdata[FLAG_BIT]) || $past(interval_evt)));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request gating wrong"); // RULE8

  property p_trim_read;
    @(posedge ref_clk) disable iff (!rstn)
      reg_rd && trim_sel && !trim_wr |=> reg_rdata == $past(trim_reg);
  endproperty
  a_trim_read: assert property (p_trim_read) else $error("trim read wrong"); // RULE10

  property p_trim_restart;
    @(posedge ref_clk) disable iff (!rstn)
      tick16 && trim_hit |=> (prescale_reg == 9'h000) && trim_done_reg;
  endproperty
  a_trim_restart: assert property (p_trim_restart) else $error("trim restart missing"); // RULE12

  property p_reset_values;
    @(posedge ref_clk)
      !rstn |=> (ctrl_reg == CTRL_RESET) && (trim_reg == TRIM_RESET);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong"); // RULE13

endmodule // rtcct_core

// ---- rtl/rtcct_pkg.sv ----
// constants and types shared by the rtc control and trim block
package rtcct_pkg;

  // register addresses
  localparam logic [7:0] CTRL_ADDR = 8'h20;
  localparam logic [7:0] TRIM_ADDR = 8'h21;

  // clock control field positions
  localparam int EXT_SEL_BIT = 7;
  localparam int TEST_B_BIT = 6;
  localparam int TEST_A_BIT = 5;
  localparam int CLKOUT_EN_BIT = 4;
  localparam int RUN_BIT = 3;
  localparam int ITS_BIT = 2;
  localparam int FLAG_BIT = 1;
  localparam int IRQ_EN_BIT = 0;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // timing: reference clock and the 32 kHz oscillator rate it stands in for
  localparam int CLK_FREQ_HZ = 250000000;
  localparam int OSC_FREQ_HZ = 32768;
  localparam int OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int OSC_CNT_W = 13;

  // divider chain end counts, in units of the stage below
  localparam logic [8:0] PRESCALE_LAST = 9'h1ff;
  localparam logic [4:0] SEC_LAST = 5'h1f;
  localparam logic [5:0] HALF_LAST = 6'h2f;
  localparam logic [5:0] MIN_LAST = 6'h3b;

  // selected interrupt interval
  typedef enum logic [2:0] {
    IVL_MIN = 3'b001,
    IVL_SEC = 3'b010,
    IVL_HALF = 3'b100
  } rtcct_interval_type;

endpackage

// ---- test/rtcct_tb.sv ----
// self-checking bench for the rtc control and trim block
`timescale 1ns/100ps
module tb;
  import rtcct_pkg::*;
  // divider shortened so a second is 32768 cycles
  localparam int SIM_DIV = 1;
  localparam int SEC_CYC = 32768 * SIM_DIV;
  localparam int HALF_CYC = 49152 * SIM_DIV;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rd_exp;
    logic irq_exp;
  } rtcct_row_type;
  // register rows: write, address, data, read-back, expected request
  localparam rtcct_row_type ROWS [8] = '{
    '{1'b1, 8'h21, 8'h3c, 8'h3c, 1'b0},
    '{1'b1, 8'h21, 8'hff, 8'hff, 1'b0},
    '{1'b1, 8'h20, 8'h96, 8'h96, 1'b0},
    '{1'b1, 8'h20, 8'h97, 8'h97, 1'b1},
    '{1'b1, 8'h20, 8'h95, 8'h95, 1'b0},
    '{1'b1, 8'h30, 8'h55, 8'h00, 1'b0},
    '{1'b0, 8'h21, 8'h00, 8'hff, 1'b0},
    '{1'b1, 8'h20, 8'h00, 8'h00, 1'b0}};
  logic ref_clk, rstn, reg_wr, reg_rd, port_ff_wr, port_ff_wdata, ext_int_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic port_ff_q, pin_out, pin_oe, pin_level, osc_enable, div_clk, rtc_irq, cpu_irq;
  int mismatches, checks_done, n;
  // quasi-bidirectional line: pulled up when nobody drives it
  wire pin_line = pin_oe ? pin_out : 1'b1;

  rtcct_core #(.OSC_DIV(SIM_DIV)) dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_ff_wr(port_ff_wr), .port_ff_wdata(port_ff_wdata), .port_ff_q(port_ff_q),
    .shared_port_clock_pin_in(pin_line), .shared_port_clock_pin_out(pin_out),
    .shared_port_clock_pin_oe(pin_oe), .pin_level(pin_level), .ext_int_n(ext_int_n),
    .osc_enable(osc_enable), .divided_clock_output(div_clk),
    .rtc_int_request(rtc_irq), .cpu_int_request(cpu_irq));

  ////////////////////////////////////////////////////////////////////////////
  // clock and shared tasks
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge ref_clk);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    data = reg_rdata;
  endtask

  task automatic port_write(input logic v);
    @(posedge ref_clk);
    port_ff_wr <= 1'b1;
    port_ff_wdata <= v;
    @(posedge ref_clk);
    port_ff_wr <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rstn, reg_wr, reg_rd, port_ff_wr, port_ff_wdata, reg_addr, reg_wdata} = '0;
    ext_int_n = 1'b1;
    mismatches = 0;
    checks_done = 0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    reg_read(CTRL_ADDR, d);
    check("ctrl reset", d, CTRL_RESET);
    reg_read(TRIM_ADDR, d);
    check("trim reset", d, TRIM_RESET);
    d = {1'b0, port_ff_q, pin_out, pin_oe, div_clk, osc_enable, rtc_irq, cpu_irq};
    check("idle outputs", d, 8'h60);
    // ordinary register cases
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) reg_write(ROWS[i].addr, ROWS[i].wdata);
      reg_read(ROWS[i].addr == 8'h30 ? 8'h30 : ROWS[i].addr, d);
      check("reg row", d, ROWS[i].rd_exp);
      repeat (3) @(posedge ref_clk);
      #1;
      check("irq row", {rtc_irq, cpu_irq}, {2{ROWS[i].irq_exp}});
    end
    // port flip-flop beside the clock output
    reg_write(CTRL_ADDR, 8'h10);
    port_write(1'b0);
    check("ff with clkout", {port_ff_q, pin_oe, pin_out ^ div_clk}, 8'h02);
    check("pin read", pin_level, pin_line);
    reg_write(CTRL_ADDR, 8'h00);
    port_write(1'b0);
    check("port line low", {pin_out, pin_oe, pin_level}, 8'h02);
    port_write(1'b1);
    check("port line high", {pin_out, pin_oe, pin_level}, 8'h05);
    // external request joins the clock request
    @(posedge ref_clk);
    ext_int_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check("ext request", {rtc_irq, cpu_irq}, 8'h01);
    @(posedge ref_clk);
    ext_int_n <= 1'b1;
    // one second interval with clock output
    reg_write(CTRL_ADDR, 8'h1d);
    check("osc on", osc_enable, 1'b1);
    n = 0;
    while (rtc_irq !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > SEC_CYC + 64) begin
        mismatches++;
        complete_run();
      end
    end
    check("second", 8'(n >= SEC_CYC - 8 && n <= SEC_CYC + 8), 8'h01);
    repeat (4) begin
      d[0] = div_clk;
      @(posedge ref_clk);
      #1;
      check("divided clock", {div_clk ^ d[0], pin_out ^ div_clk, pin_oe}, 8'h05);
    end
    reg_write(CTRL_ADDR, 8'h1d);
    check("flag cleared", rtc_irq, 1'b0);
    // stop clears the chain and holds it at zero
    reg_write(CTRL_ADDR, 8'h00);
    // the write edge itself may still toggle the clock; it clears one edge later
    @(posedge ref_clk);
    #1;
    d[0] = div_clk;
    repeat (20) @(posedge ref_clk);
    #1;
    check("stopped", {osc_enable, div_clk, div_clk ^ d[0]}, 8'h00);
    // one and a half seconds, request masked
    reg_write(CTRL_ADDR, 8'h8c);
    repeat (HALF_CYC - 24) @(posedge ref_clk);
    reg_read(CTRL_ADDR, d);
    check("before half", d, 8'h8c);
    repeat (40) @(posedge ref_clk);
    reg_read(CTRL_ADDR, d);
    check("after half", d, 8'h8e);
    check("masked", rtc_irq, 1'b0);
    // reset in mid-run: registers and chain go back to their reset state
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    reg_read(TRIM_ADDR, d);
    check("trim mid reset", d, TRIM_RESET);
    reg_read(CTRL_ADDR, d);
    check("ctrl mid reset", d, CTRL_RESET);
    check("chain mid reset", {osc_enable, div_clk, port_ff_q}, 8'h01);
    complete_run();
  end
endmodule // tb
